// [rtl/lmx_pkg.sv]
// Purpose: Shared constants and helpers for the LED multiplex serial write port.
// Assumes: One system clock; sclk, cs_n, din and mux_clock_in are synchronised inside the top module.
// Notes: Segment data bit order is dp in bit 7, then a, b, c, d, e, f, g from bit 6 down.
package lmx_pkg;

  // Command word layout: address in the upper byte, data in the lower byte.
  localparam int WORD_W = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Digit data writes: plane 0 only, or both planes, eight digits each.
  localparam logic [7:0] ADDR_DIG_P0 = 8'h20;
  localparam logic [7:0] ADDR_DIG_BOTH = 8'h60;
  localparam logic [7:0] ADDR_DIG_MASK = 8'hF8;
  localparam logic [7:0] DIGIT_RST = 8'h00;

  // Scan geometry: eight scan slots, all eight with a cathode driver.
  localparam int NUM_DIGITS = 8;
  localparam logic [3:0] DIGIT_DRIVERS = 4'h8;

  // Multiplex timing: ticks per digit slot and the internal oscillator divider.
  localparam logic [5:0] SLOT_TICKS = 6'h20;
  localparam logic [3:0] INT_OSC_DIV = 4'hA;

  // Segment bit positions inside a digit byte.
  localparam int DECIMAL_POINT_SEGMENT = 7;
  localparam int SEG_A = 6;

  // Returns the segment that shared pin j carries while digit k is scanned.
  // Pins below k take positions 0.., pins above k shift down by one.
  function automatic logic seg_for_pin(input logic [7:0] d, input logic [2:0] k,
                                       input logic [2:0] j);
    logic [6:0] seq;
    logic [2:0] pos;
    seq = {d[5], d[4], d[3], d[2], d[1], d[0], d[DECIMAL_POINT_SEGMENT]};
    pos = (j < k) ? j : 3'(j - 3'h1);
    return seq[pos];
  endfunction : seg_for_pin

endpackage : lmx_pkg

// [rtl/lmx_scan_if.sv]
// Purpose: Carries the scan timing and digit data between the port and the scanner.
// Assumes: Both ends run on clk_sys.
// Notes: The scanner asks for a digit by index and gets its byte back combinationally.
`timescale 1ns/10ps
`default_nettype none
interface lmx_scan_if;
  logic mux_tick; // One-cycle pulse per multiplex clock period.
  logic [2:0] scan_limit; // Highest digit index that is scanned.
  logic [2:0] digit; // Digit currently scanned.
  logic [7:0] seg_pattern; // Segment byte of that digit.
  modport port (output mux_tick, output scan_limit, output seg_pattern, input digit);
  modport scan (input mux_tick, input scan_limit, input seg_pattern, output digit);
endinterface : lmx_scan_if
`default_nettype wire

// [rtl/lmx_scan.sv]
// Purpose: Multiplex scanner that drives the shared cathode and segment pins.
// Assumes: mux_tick is a clean one-cycle pulse on clk_sys.
// Notes: Unlit segments are left floating rather than driven low.
`timescale 1ns/10ps
`default_nettype none
module lmx_scan
  import lmx_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  lmx_scan_if.scan sif, // Timing and digit data.
  output logic [7:0] pin_out_r, // Shared pin drive level.
  output logic [7:0] pin_oe_r, // Shared pin drive enable.
  output logic seg_a_out_r, // Fixed segment a level.
  output logic seg_a_oe_r // Fixed segment a enable.
);

  logic [5:0] slot_r, slot_nxt; // Ticks spent in the current slot.
  logic [2:0] digit_r, digit_nxt; // Digit being scanned.
  logic [7:0] pin_out_nxt, pin_oe_nxt;
  logic seg_a_out_nxt, seg_a_oe_nxt;

  assign sif.digit = digit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Slot sequencing and pin pattern; outputs are registered so pins never glitch.
  always_comb begin
    slot_nxt = slot_r;
    digit_nxt = digit_r;
    if (sif.mux_tick) begin
      if (slot_r == 6'(SLOT_TICKS - 6'h1)) begin
        slot_nxt = 6'h00;
        digit_nxt = (digit_r >= sif.scan_limit) ? 3'h0 : 3'(digit_r + 3'h1);
      end else begin
        slot_nxt = 6'(slot_r + 6'h1);
      end
    end
    pin_out_nxt = 8'h00;
    pin_oe_nxt = 8'h00;
    seg_a_out_nxt = 1'b0;
    seg_a_oe_nxt = 1'b0;
    // A digit with no cathode driver stays dark; every pin floats.
    if ({1'b0, digit_r} < DIGIT_DRIVERS) begin
      for (int j = 0; j < NUM_DIGITS; j++) begin
        if (3'(j) == digit_r) begin
          pin_oe_nxt[j] = 1'b1;
        end else if (seg_for_pin(sif.seg_pattern, digit_r, 3'(j))) begin
          pin_out_nxt[j] = 1'b1;
          pin_oe_nxt[j] = 1'b1;
        end
      end
      seg_a_out_nxt = sif.seg_pattern[SEG_A];
      seg_a_oe_nxt = sif.seg_pattern[SEG_A];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot_r <= 6'h00;
      digit_r <= 3'h0;
      pin_out_r <= 8'h00;
      pin_oe_r <= 8'h00;
      seg_a_out_r <= 1'b0;
      seg_a_oe_r <= 1'b0;
    end else begin
      slot_r <= slot_nxt;
      digit_r <= digit_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      seg_a_out_r <= seg_a_out_nxt;
      seg_a_oe_r <= seg_a_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pin pattern and the digit step.
  property p_one_cathode;
    @(posedge clk_sys) disable iff (rst) $onehot0(pin_oe_r & ~pin_out_r);
  endproperty
  a_one_cathode: assert property (p_one_cathode) else $error("More than one cathode sinks.");

  property p_float_off;
    @(posedge clk_sys) disable iff (rst) (pin_out_r & ~pin_oe_r) == 8'h00;
  endproperty
  a_float_off: assert property (p_float_off) else $error("Driven high while not enabled.");

  property p_no_driver_dark;
    @(posedge clk_sys) disable iff (rst) ({1'b0, digit_r} >= DIGIT_DRIVERS) |=> pin_oe_r == 8'h00;
  endproperty
  a_no_driver_dark: assert property (p_no_driver_dark) else $error("Absent digit lit.");

  property p_seg_a;
    @(posedge clk_sys) disable iff (rst)
      ({1'b0, digit_r} < DIGIT_DRIVERS) |=> seg_a_oe_r == $past(sif.seg_pattern[SEG_A]);
  endproperty
  a_seg_a: assert property (p_seg_a) else $error("Segment a does not follow its bit.");

  property p_cathode_pin;
    @(posedge clk_sys) disable iff (rst)
      ({1'b0, digit_r} < DIGIT_DRIVERS) |=> pin_oe_r[$past(digit_r)] && !pin_out_r[$past(digit_r)];
  endproperty
  a_cathode_pin: assert property (p_cathode_pin) else $error("Cathode pin not sinking.");

  property p_slot_step;
    @(posedge clk_sys) disable iff (rst)
      sif.mux_tick && slot_r == 6'(SLOT_TICKS - 6'h1) && digit_r < sif.scan_limit
      |=> digit_r == $past(digit_r) + 3'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("Digit did not advance.");

endmodule : lmx_scan
`default_nettype wire

// [rtl/lmx_top.sv]
// Purpose: Write-only three-wire serial command port with a multiplexed LED scanner.
// Assumes: sclk, cs_n, din and mux_clock_in are asynchronous pins, all far slower than clk_sys.
// Notes: Only digit-data writes of plane 0 are acted on here; other commands are
//   presented on cmd_word_r for the rest of the chip to decode.
//
// Functional notes
// - Shift data in on each serial clock rise.
// - Select high: serial clock edges ignored.
// - Select rise latches the last sixteen bits.
// - Word is address byte then data byte.
// - Serial clock may idle low or high.
// - Own digit pin sinks; others source segments.
// - Idle drivers float, driving neither level.
// - Five-digit variant: upper three digits stay dark (DIGIT_DRIVERS is 8 here, so all eight digits have drivers).
// - Digit k: pin k cathode, fixed pin segment a.
// - Odd bit counts keep the final sixteen bits.
// - Port is write-only; nothing reads back.
`timescale 1ns/10ps
`default_nettype none
module lmx_top
  import lmx_pkg::*;
(
  input wire logic clk_sys, // System clock, 40 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic sclk, // Serial clock pin.
  input wire logic cs_n, // Serial select pin, active low.
  input wire logic din, // Serial data pin.
  input wire logic mux_clock_in, // External multiplex clock pin.
  input wire logic mux_clock_sel, // Static select: 1 uses mux_clock_in.
  input wire logic [2:0] scan_limit, // Highest digit index scanned.
  output logic [15:0] cmd_word_r, // Last latched command word.
  output logic cmd_valid_r, // One-cycle pulse when a word is latched.
  output logic [7:0] shared_drive_pin_out, // Shared pin level.
  output logic [7:0] shared_drive_pin_oe, // Shared pin enable.
  output logic fixed_segment_a_out, // Segment a level.
  output logic fixed_segment_a_oe // Segment a enable.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stage of each is read only by the second.
  logic [3:0] meta_r; // First stages: sclk, cs_n, din, mux clock.
  logic [3:0] sync_r; // Second stages.
  logic sclk_d_r; // Previous synced sclk, for edge finding.
  logic cs_d_r; // Previous synced select.
  logic mux_d_r; // Previous synced multiplex clock.
  logic sclk_q, cs_q, din_q, mux_q;

  assign sclk_q = sync_r[0];
  assign cs_q = sync_r[1];
  assign din_q = sync_r[2];
  assign mux_q = sync_r[3];

  // Select idles high after reset, so a start-up high never looks like a frame end.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= 4'h2;
      sync_r <= 4'h2;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      mux_d_r <= 1'b0;
    end else begin
      meta_r <= {mux_clock_in, din, cs_n, sclk};
      sync_r <= meta_r;
      sclk_d_r <= sclk_q;
      cs_d_r <= cs_q;
      mux_d_r <= mux_q;
    end
  end

  // Only a low-to-high change counts, so either idle level is harmless.
  logic sclk_rise; // Serial clock rising edge.
  logic cs_rise; // End of a frame.
  logic mux_rise; // External multiplex clock rising edge.
  assign sclk_rise = sclk_q && !sclk_d_r;
  assign cs_rise = cs_q && !cs_d_r;
  assign mux_rise = mux_q && !mux_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and word latch. The shift register is cleared only by reset, so a
  // short frame carries bits over from the one before it.
  logic [15:0] shift_r, shift_nxt; // Serial shift register.
  logic [15:0] cmd_word_nxt;
  logic cmd_valid_nxt;

  always_comb begin
    shift_nxt = shift_r;
    cmd_word_nxt = cmd_word_r;
    cmd_valid_nxt = 1'b0;
    // Edges while deselected are dropped; the bus may serve other parts.
    if (sclk_rise && !cs_q) begin
      shift_nxt = {shift_r[WORD_W-2:0], din_q};
    end
    if (cs_rise) begin
      cmd_word_nxt = shift_r;
      cmd_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_r <= WORD_RST;
      cmd_word_r <= WORD_RST;
      cmd_valid_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cmd_word_r <= cmd_word_nxt;
      cmd_valid_r <= cmd_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digit store. Written from latched words; there is no path back to the
  // serial pins, so nothing can be read out.
  logic [7:0] digit_ram [NUM_DIGITS]; // Segment bytes, plane 0.
  logic [7:0] ram_nxt [NUM_DIGITS];
  logic [7:0] cmd_addr; // Address byte of the latched word.
  logic [7:0] cmd_data; // Data byte of the latched word.
  logic dig_write; // Latched word targets plane 0 of a digit.

  assign cmd_addr = cmd_word_r[ADDR_HI:ADDR_LO];
  assign cmd_data = cmd_word_r[DATA_HI:DATA_LO];
  assign dig_write = cmd_valid_r &&
    (((cmd_addr & ADDR_DIG_MASK) == ADDR_DIG_P0) || ((cmd_addr & ADDR_DIG_MASK) == ADDR_DIG_BOTH));

  always_comb begin
    ram_nxt = digit_ram;
    if (dig_write) begin
      ram_nxt[cmd_addr[2:0]] = cmd_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_DIGITS; i++) begin
        digit_ram[i] <= DIGIT_RST;
      end
    end else begin
      digit_ram <= ram_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiplex tick. The internal source divides clk_sys; the external one is
  // trusted to stay in its allowed range, which keeps it well below clk_sys / 4.
  logic [3:0] osc_cnt_r, osc_cnt_nxt; // Internal oscillator divider.
  logic tick_r, tick_nxt; // Multiplex tick pulse.

  always_comb begin
    osc_cnt_nxt = (osc_cnt_r == 4'(INT_OSC_DIV - 4'h1)) ? 4'h0 : 4'(osc_cnt_r + 4'h1);
    tick_nxt = mux_clock_sel ? mux_rise : (osc_cnt_r == 4'h0);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      osc_cnt_r <= osc_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scanner.
  lmx_scan_if sif ();
  assign sif.mux_tick = tick_r;
  assign sif.scan_limit = scan_limit;
  assign sif.seg_pattern = digit_ram[sif.digit];

  lmx_scan u_scan (
    .clk_sys(clk_sys),
    .rst(rst),
    .sif(sif),
    .pin_out_r(shared_drive_pin_out),
    .pin_oe_r(shared_drive_pin_oe),
    .seg_a_out_r(fixed_segment_a_out),
    .seg_a_oe_r(fixed_segment_a_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the serial port.
  property p_shift_in;
    @(posedge clk_sys) disable iff (rst)
      sclk_rise && !cs_q |=> shift_r == {$past(shift_r[14:0]), $past(din_q)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("Bit not shifted in.");

  property p_desel_hold;
    @(posedge clk_sys) disable iff (rst) cs_q |=> $stable(shift_r);
  endproperty
  a_desel_hold: assert property (p_desel_hold) else $error("Shifted while deselected.");

  property p_latch;
    @(posedge clk_sys) disable iff (rst)
      cs_rise |=> cmd_valid_r && cmd_word_r == $past(shift_r);
  endproperty
  a_latch: assert property (p_latch) else $error("Word not latched on select rise.");

  property p_idle_clock;
    @(posedge clk_sys) disable iff (rst) !sclk_rise |=> $stable(shift_r);
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("Shift without a clock rise.");

  property p_word_hold;
    @(posedge clk_sys) disable iff (rst) !cs_rise |=> $stable(cmd_word_r) && !cmd_valid_r;
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("Word changed outside a latch.");

  property p_digit_store;
    @(posedge clk_sys) disable iff (rst)
      dig_write |=> digit_ram[$past(cmd_addr[2:0])] == $past(cmd_data);
  endproperty
  a_digit_store: assert property (p_digit_store) else $error("Digit byte not stored.");

endmodule : lmx_top
`default_nettype wire

// [verif/lmx_host_model.sv]
// Purpose: Behavioural host that writes words over the three-wire serial link.
// Assumes: Paced by clk_sys falling edges; half a link period is four clk_sys cycles.
// Notes: Data is inverted on release so that a stale bit never looks valid.
`timescale 1ns/10ps
`default_nettype none
module lmx_host_model (
  input wire logic clk_sys, // Pacing clock.
  output var logic sclk, // Serial clock; outside frames it moves only during noise and when a frame sets its idle level.
  output var logic cs_n, // Select, active low.
  output var logic din // Serial data.
);
  // Deselected and quiet at time zero.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Waits n falling edges of the pacing clock.
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : hold

  // Sends the low n bits of w, highest first; the idle level is set before select falls.
  task automatic frame(input logic [31:0] w, input int n, input logic idle);
    sclk = idle;
    hold(4);
    cs_n = 1'b0;
    hold(4);
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      sclk = 1'b0;
      hold(4);
      sclk = 1'b1;
      hold(4);
    end
    sclk = idle;
    hold(4);
    cs_n = 1'b1;
    din = ~din;
    hold(4);
  endtask : frame

  // Toggles the clock with select high, as traffic meant for another device.
  task automatic noise(input int n, input logic [31:0] pat);
    for (int i = 0; i < n; i++) begin
      din = pat[i];
      sclk = ~sclk;
      hold(4);
    end
  endtask : noise
endmodule : lmx_host_model
`default_nettype wire

// [verif/lmx_top_tb.sv]
// Purpose: Self-checking bench for the serial write port and the scanner.
// Assumes: Words are modelled by a shadow shift register kept by the bench.
// Notes: Scan pins are checked only while no write is in flight.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module lmx_top_tb;
  import lmx_pkg::*;
  logic clk_sys, rst, sclk, cs_n, din, mux_clock_in, mux_clock_sel, cmd_valid_r;
  logic fixed_segment_a_out, fixed_segment_a_oe, scan_on, have, have2;
  logic [2:0] scan_limit;
  logic [15:0] cmd_word_r, sh, ew;
  logic [7:0] shared_drive_pin_out, shared_drive_pin_oe, cath, pins;
  logic [7:0] dig [8];
  logic [15:0] exp_q [$];
  int err_count, checks, k, pk, run, slot_len;
  integer seed;

  lmx_top u_dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .mux_clock_in(mux_clock_in), .mux_clock_sel(mux_clock_sel), .scan_limit(scan_limit),
    .cmd_word_r(cmd_word_r), .cmd_valid_r(cmd_valid_r),
    .shared_drive_pin_out(shared_drive_pin_out), .shared_drive_pin_oe(shared_drive_pin_oe),
    .fixed_segment_a_out(fixed_segment_a_out), .fixed_segment_a_oe(fixed_segment_a_oe));
  lmx_host_model u_host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .din(din));

  ////////////////////////////////////////////////////////////////////////////////////////////
  // System clock at 40 MHz; the multiplex clock runs at 5 MHz in an unrelated phase.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    mux_clock_in = 1'b0;
    #7;
    forever #100 mux_clock_in = ~mux_clock_in;
  end

  // Expected pin levels for digit byte d with digit c scanned; the cathode pin is left low.
  function automatic logic [7:0] seg_pins(input logic [7:0] d, input int c);
    logic [6:0] s;
    int p;
    s = {d[5], d[4], d[3], d[2], d[1], d[0], d[7]};
    p = 0;
    seg_pins = 8'h00;
    for (int j = 0; j < 8; j++) begin
      if (j != c) begin
        seg_pins[j] = s[p];
        p++;
      end
    end
  endfunction : seg_pins

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Shifts the frame into the shadow register, notes the word, sends it, awaits the latch.
  task automatic send(input logic [31:0] w, input int n, input logic idle);
    int t;
    for (int i = n - 1; i >= 0; i--) sh = {sh[14:0], w[i]};
    if ((sh[15:8] & ADDR_DIG_MASK) inside {ADDR_DIG_P0, ADDR_DIG_BOTH}) dig[sh[10:8]] = sh[7:0];
    exp_q.push_back(sh);
    u_host.frame(w, n, idle);
    t = 0;
    while (exp_q.size() != 0 && t < 8) begin
      @(negedge clk_sys);
      t++;
    end
    `CHK("word latency", 0, exp_q.size())
    exp_q.delete();
  endtask : send

  // Watches the scan for two full rounds with the given slot length in cycles.
  task automatic scan_phase(input int len);
    slot_len = len;
    have = 1'b0;
    have2 = 1'b0;
    run = 0;
    repeat (4) @(negedge clk_sys);
    scan_on = 1'b1;
    repeat (2 * (32'(scan_limit) + 1) * len + 20) @(negedge clk_sys);
    scan_on = 1'b0;
  endtask : scan_phase

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Every latched word must match the oldest note; a word with no note is spurious.
  always @(negedge clk_sys) begin
    if (rst === 1'b0 && cmd_valid_r === 1'b1) begin
      if (exp_q.size() == 0) `CHK("spurious word", 1'b0, cmd_valid_r)
      else begin
        ew = exp_q.pop_front();
        `CHK("cmd word", ew, cmd_word_r)
      end
    end
  end

  // Finds the one sinking pin and checks every pin, the digit order and the slot length.
  always @(negedge clk_sys) begin
    if (scan_on === 1'b1) begin
      cath = shared_drive_pin_oe & ~shared_drive_pin_out;
      `CHK("cathode count", 1, $countones(cath))
      k = 0;
      for (int j = 0; j < 8; j++) if (cath[j]) k = j;
      pins = seg_pins(dig[k], k);
      `CHK("pin level", pins, shared_drive_pin_out)
      `CHK("pin enable", pins | (8'h01 << k), shared_drive_pin_oe)
      `CHK("seg a", ({2{dig[k][SEG_A]}}), ({fixed_segment_a_out, fixed_segment_a_oe}))
      if (have && k != pk) begin
        `CHK("next digit", (pk == 32'(scan_limit)) ? 0 : pk + 1, k)
        if (have2) `CHK("slot length", slot_len, run)
        have2 = 1'b1;
        run = 0;
      end
      run++;
      pk = k;
      have = 1'b1;
    end
  end

  // A hang is cut short well beyond the expected run of some 10500 cycles.
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence: digit writes at both idle levels, stray traffic, odd lengths, two scans.
  initial begin
    seed = 32'h4158C5B4;
    rst = 1'b1;
    mux_clock_sel = 1'b0;
    scan_limit = 3'h7;
    scan_on = 1'b0;
    sh = WORD_RST;
    foreach (dig[i]) dig[i] = DIGIT_RST;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      send({16'h0000, (i[0] ? ADDR_DIG_BOTH : ADDR_DIG_P0) | 8'(i), 8'($random(seed))}, 16, i[1]);
    end
    send({16'h0000, 8'h43, 8'($random(seed))}, 16, 1'b0);
    u_host.noise(10, $random(seed));
    send($random(seed), 8, 1'b1);
    send($random(seed), 20, 1'b0);
    repeat (3) send($random(seed), 12 + ($random(seed) & 7), 1'b0);
    scan_phase(32'(SLOT_TICKS) * 32'(INT_OSC_DIV));
    rst = 1'b1;
    mux_clock_sel = 1'b1;
    scan_limit = 3'h4;
    sh = WORD_RST;
    foreach (dig[i]) dig[i] = DIGIT_RST;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) send({16'h0000, ADDR_DIG_P0 | 8'(i), 8'($random(seed))}, 16, 1'b0);
    scan_phase(32'(SLOT_TICKS) * 8);
    end_sim();
  end
endmodule : lmx_top_tb
`default_nettype wire
